// *** verilog/wit_defs.svh ***
`ifndef WIT_DEFS_SVH
`define WIT_DEFS_SVH
// device bus map
`define WIT_CSR_RD_ADDR 16'hffa8
`define WIT_CNT_RD_ADDR 16'hffa9
`define WIT_WR_ADDR 16'hffaa
`define WIT_SYSCTL_ADDR 16'hffc4
`define WIT_PASS_CNT 8'h5a
`define WIT_PASS_CSR 8'ha5
// control/status field positions
`define WIT_FLAG_BIT 7
`define WIT_MODE_BIT 6
`define WIT_RUN_BIT 5
`define WIT_ACT_BIT 3
`define WIT_DIV_MSB 2
`define WIT_CNT_RESET 8'h00
`define WIT_RSVD_VALUE 1'b1
`define WIT_PIN_RST_BIT 0
// prescaler masks: tick every 2,32,64,128,256,512,2048,4096 clocks
`define WIT_DIV0_MASK 12'h001
`define WIT_DIV1_MASK 12'h01f
`define WIT_DIV2_MASK 12'h03f
`define WIT_DIV3_MASK 12'h07f
`define WIT_DIV4_MASK 12'h0ff
`define WIT_DIV5_MASK 12'h1ff
`define WIT_DIV6_MASK 12'h7ff
`define WIT_DIV7_MASK 12'hfff
`define WIT_RESET_HOLD 10'd518
// controller AXI4-Lite map
`define WIT_H_CMD 6'h00
`define WIT_H_STATUS 6'h01
`define WIT_H_CTRL 6'h02
`define WIT_H_EVENTS 6'h03
`define WIT_KICK_CYCLES 1000
`define WIT_AXI_OKAY 2'b00
`endif

// *** verilog/wit_pkg.sv ***
`default_nettype none
package wit_pkg;
  typedef enum logic [2:0] {
    WIT_T_WR_CNT = 3'h0,
    WIT_T_WR_CSR = 3'h1,
    WIT_T_RD_CSR = 3'h2,
    WIT_T_RD_CNT = 3'h3,
    WIT_T_RD_SYS = 3'h4,
    WIT_T_RAW_BYTE = 3'h5,
    WIT_T_RAW_WORD = 3'h6,
    WIT_T_NONE = 3'h7
  } wit_target_t;
  typedef enum {WIT_IDLE, WIT_ISSUE, WIT_WAIT} wit_host_state_t;
endpackage : wit_pkg
`default_nettype wire

// *** verilog/wit_bus_if.sv ***
`timescale 1ns/1ns
`default_nettype none
interface wit_bus_if;
  logic req;
  logic we;
  logic word;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic ack;
  logic [7:0] rdata;
  logic ext_reset_n;
  logic standby_exit;
  logic chip_reset_n;
  logic nmi_req;
  logic overflow_irq;
  modport device (
    input req, we, word, addr, wdata, ext_reset_n, standby_exit,
    output ack, rdata, chip_reset_n, nmi_req, overflow_irq
  );
  modport host (
    output req, we, word, addr, wdata, ext_reset_n, standby_exit,
    input ack, rdata, chip_reset_n, nmi_req, overflow_irq
  );
endinterface : wit_bus_if
`default_nettype wire

// *** verilog/wit_device.sv ***
// Notes on behaviour
// - count wrap ff to 00 sets flag
// - mode bit: interval or watchdog
// - run bit low holds count zero
// - bit 4 reads one, ignores writes
// - action bit: nmi or chip reset
// - divider picks one of eight ratios
// - writes only as word accesses
// - one write address, password selects target
// - byte reads at ffa8 and ffa9
// - reset action holds chip 518 cycles
// - software rewrites count to avoid overflow
// - vectors shared with external pins
// - reset source kept in system control
// - interval mode requests every overflow
// - flag and request in same cycle
// - count write beats coincident tick
// - stop timer before changing divider
// - standby exit clears all but divider
// - flag clears by write 0 after read
// - eight-bit up-counter while running
`timescale 1ns/1ns
`default_nettype none
`include "wit_defs.svh"
module wit_device
  import wit_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  wit_bus_if.device bus,
  output logic overflow_flag,
  output logic [7:0] watchdog_count
);

  logic ext_meta;
  logic ext_sync;
  logic local_rst;
  logic standby;
  logic timer_mode_select;
  logic run_enable;
  logic overflow_action;
  logic [2:0] clock_divider_select;
  logic clear_armed;
  logic [11:0] prescale;
  logic [11:0] div_mask;
  logic tick;
  logic overflow;
  logic [9:0] hold_cnt;
  logic external_reset_indicator;
  logic wr_word;
  logic wr_cnt;
  logic wr_csr;
  logic rd;
  logic [7:0] csr_value;

  ////////////////////////////////////////////////////////////////////
  // external reset pin, two-stage synchroniser

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_meta <= 1'b1;
      ext_sync <= 1'b1;
    end else begin
      ext_meta <= bus.ext_reset_n;
      ext_sync <= ext_meta;
    end
  end

  assign local_rst = !aresetn || !ext_sync;
  assign standby = bus.standby_exit;

  ////////////////////////////////////////////////////////////////////
  // bus decode

  // byte writes never reach the registers
  assign wr_word = bus.req && bus.we && bus.word && (bus.addr == `WIT_WR_ADDR);
  assign wr_cnt = wr_word && (bus.wdata[15:8] == `WIT_PASS_CNT);
  assign wr_csr = wr_word && (bus.wdata[15:8] == `WIT_PASS_CSR);
  assign rd = bus.req && !bus.we;

  assign csr_value = {overflow_flag, timer_mode_select, run_enable,
                      `WIT_RSVD_VALUE, overflow_action, clock_divider_select};

  ////////////////////////////////////////////////////////////////////
  // prescaler

  always_comb begin
    case (clock_divider_select)
      3'h0: div_mask = `WIT_DIV0_MASK;
      3'h1: div_mask = `WIT_DIV1_MASK;
      3'h2: div_mask = `WIT_DIV2_MASK;
      3'h3: div_mask = `WIT_DIV3_MASK;
      3'h4: div_mask = `WIT_DIV4_MASK;
      3'h5: div_mask = `WIT_DIV5_MASK;
      3'h6: div_mask = `WIT_DIV6_MASK;
      default: div_mask = `WIT_DIV7_MASK;
    endcase
  end

  // restarts with the timer so the first interval is a full one
  always_ff @(posedge aclk) begin
    if (local_rst || !run_enable) begin
      prescale <= 12'h000;
    end else begin
      prescale <= prescale + 12'h001;
    end
  end

  // a divider change mid-run can skip or double a tick
  assign tick = run_enable && ((prescale & div_mask) == div_mask);

  // wrap only on a real increment, never on a loaded value
  assign overflow = tick && !wr_cnt && (watchdog_count == 8'hff);

  ////////////////////////////////////////////////////////////////////
  // counter

  always_ff @(posedge aclk) begin
    if (local_rst || standby) begin
      watchdog_count <= `WIT_CNT_RESET;
    end else if (!run_enable) begin
      watchdog_count <= `WIT_CNT_RESET;
    end else if (wr_cnt) begin
      watchdog_count <= bus.wdata[7:0];
    end else if (tick) begin
      watchdog_count <= watchdog_count + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // control/status fields

  always_ff @(posedge aclk) begin
    if (local_rst) begin
      timer_mode_select <= 1'b0;
      run_enable <= 1'b0;
      overflow_action <= 1'b0;
      clock_divider_select <= 3'h0;
    end else if (standby) begin
      timer_mode_select <= 1'b0;
      run_enable <= 1'b0;
      overflow_action <= 1'b0;
    end else if (wr_csr) begin
      timer_mode_select <= bus.wdata[`WIT_MODE_BIT];
      run_enable <= bus.wdata[`WIT_RUN_BIT];
      overflow_action <= bus.wdata[`WIT_ACT_BIT];
      clock_divider_select <= bus.wdata[`WIT_DIV_MSB:0];
    end
  end

  // read of a set flag arms the clear
  always_ff @(posedge aclk) begin
    if (local_rst || standby) begin
      clear_armed <= 1'b0;
    end else if (wr_csr && !bus.wdata[`WIT_FLAG_BIT]) begin
      clear_armed <= 1'b0;
    end else if (rd && (bus.addr == `WIT_CSR_RD_ADDR) && overflow_flag) begin
      clear_armed <= 1'b1;
    end
  end

  // a new overflow wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (local_rst || standby) begin
      overflow_flag <= 1'b0;
    end else if (overflow) begin
      overflow_flag <= 1'b1;
    end else if (wr_csr && !bus.wdata[`WIT_FLAG_BIT] && clear_armed) begin
      overflow_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // overflow actions, registered on the same edge as the flag

  always_ff @(posedge aclk) begin
    if (local_rst) begin
      bus.overflow_irq <= 1'b0;
      bus.nmi_req <= 1'b0;
    end else begin
      bus.overflow_irq <= overflow && !timer_mode_select;
      // same pulse as the external nmi pin feeds the core
      bus.nmi_req <= overflow && timer_mode_select && !overflow_action;
    end
  end

  // the module itself is not reset by its own chip reset
  always_ff @(posedge aclk) begin
    if (local_rst) begin
      hold_cnt <= 10'd0;
      bus.chip_reset_n <= 1'b1;
    end else if (overflow && timer_mode_select && overflow_action) begin
      hold_cnt <= `WIT_RESET_HOLD;
      bus.chip_reset_n <= 1'b0;
    end else if (hold_cnt != 10'd0) begin
      hold_cnt <= hold_cnt - 10'd1;
      bus.chip_reset_n <= (hold_cnt == 10'd1);
    end
  end

  // 1 after a pin or power-on reset, 0 after a watchdog reset
  always_ff @(posedge aclk) begin
    if (local_rst) begin
      external_reset_indicator <= 1'b1;
    end else if (overflow && timer_mode_select && overflow_action) begin
      external_reset_indicator <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read port: every request is acknowledged one cycle later

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus.ack <= 1'b0;
      bus.rdata <= 8'h00;
    end else begin
      bus.ack <= bus.req;
      if (rd && (bus.addr == `WIT_CSR_RD_ADDR)) begin
        bus.rdata <= csr_value;
      end else if (rd && (bus.addr == `WIT_CNT_RD_ADDR)) begin
        bus.rdata <= watchdog_count;
      end else if (rd && (bus.addr == `WIT_SYSCTL_ADDR)) begin
        bus.rdata <= {7'h00, external_reset_indicator};
      end else begin
        bus.rdata <= 8'h00;
      end
    end
  end

endmodule : wit_device
`default_nettype wire

// *** verilog/wit_host.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "wit_defs.svh"
module wit_host
  import wit_pkg::*;
#(
  parameter int KICK_CYCLES = `WIT_KICK_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  wit_bus_if.host bus
);

  wit_host_state_t state;
  logic aw_got;
  logic w_got;
  logic [5:0] aw_idx;
  logic [31:0] w_q;
  logic do_write;
  logic cmd_go;
  logic kick_go;
  logic [15:0] kick_cnt;
  logic [2:0] ctrl;
  logic [2:0] events;
  logic [7:0] last_rdata;
  wit_target_t tgt;
  logic [31:0] status;

  ////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channels

  assign do_write = aw_got && w_got && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      aw_got <= 1'b0;
      aw_idx <= 6'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_got <= 1'b1;
      aw_idx <= s_axi_awaddr[7:2];
    end else if (do_write) begin
      aw_got <= 1'b0;
    end else if (!aw_got && !s_axi_bvalid) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b0;
      w_got <= 1'b0;
      w_q <= 32'h0000_0000;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_got <= 1'b1;
      w_q <= s_axi_wdata;
    end else if (do_write) begin
      w_got <= 1'b0;
    end else if (!w_got && !s_axi_bvalid) begin
      s_axi_wready <= 1'b1;
    end
  end

  // byte strobes ignored: each register is written as a whole word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `WIT_AXI_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // controller registers

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= 3'h0;
    end else if (do_write && (aw_idx == `WIT_H_CTRL)) begin
      ctrl <= w_q[2:0];
    end else begin
      ctrl[1] <= 1'b0;
    end
  end

  // sticky device events; a new event wins over write-one-to-clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      events <= 3'h0;
    end else begin
      events <= (events & ~((do_write && (aw_idx == `WIT_H_EVENTS)) ? w_q[2:0] : 3'h0))
                | {!bus.chip_reset_n, bus.overflow_irq, bus.nmi_req};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus.ext_reset_n <= 1'b1;
      bus.standby_exit <= 1'b0;
    end else begin
      bus.ext_reset_n <= !ctrl[0];
      bus.standby_exit <= ctrl[1];
    end
  end

  assign status = {16'h0000, last_rdata, 5'h00, bus.chip_reset_n, ctrl[2],
                   (state != WIT_IDLE)};

  ////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `WIT_AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      case (s_axi_araddr[7:2])
        `WIT_H_STATUS: s_axi_rdata <= status;
        `WIT_H_CTRL: s_axi_rdata <= {29'h0, ctrl};
        `WIT_H_EVENTS: s_axi_rdata <= {29'h0, events};
        default: s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // device bus sequencer

  // commands while busy are dropped; software polls busy first
  assign tgt = wit_target_t'(w_q[18:16]);
  assign cmd_go = do_write && (aw_idx == `WIT_H_CMD) && (tgt != WIT_T_NONE);
  assign kick_go = ctrl[2] && (kick_cnt == 16'(KICK_CYCLES - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn || !ctrl[2]) begin
      kick_cnt <= 16'h0000;
    end else if (kick_go) begin
      kick_cnt <= 16'h0000;
    end else begin
      kick_cnt <= kick_cnt + 16'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= WIT_IDLE;
      bus.req <= 1'b0;
      bus.we <= 1'b0;
      bus.word <= 1'b0;
      bus.addr <= 16'h0000;
      bus.wdata <= 16'h0000;
      last_rdata <= 8'h00;
    end else begin
      case (state)
        WIT_IDLE: begin
          if (cmd_go) begin
            state <= WIT_ISSUE;
            bus.req <= 1'b1;
            bus.we <= (tgt == WIT_T_WR_CNT) || (tgt == WIT_T_WR_CSR) ||
                      (tgt == WIT_T_RAW_BYTE) || (tgt == WIT_T_RAW_WORD);
            bus.word <= (tgt == WIT_T_WR_CNT) || (tgt == WIT_T_WR_CSR) ||
                        (tgt == WIT_T_RAW_WORD);
            case (tgt)
              WIT_T_WR_CNT: bus.wdata <= {`WIT_PASS_CNT, w_q[7:0]};
              WIT_T_WR_CSR: bus.wdata <= {`WIT_PASS_CSR, w_q[7:0]};
              WIT_T_RAW_WORD: bus.wdata <= w_q[15:0];
              default: bus.wdata <= {8'h00, w_q[7:0]};
            endcase
            case (tgt)
              WIT_T_RD_CSR: bus.addr <= `WIT_CSR_RD_ADDR;
              WIT_T_RD_CNT: bus.addr <= `WIT_CNT_RD_ADDR;
              WIT_T_RD_SYS: bus.addr <= `WIT_SYSCTL_ADDR;
              default: bus.addr <= `WIT_WR_ADDR;
            endcase
          end else if (kick_go) begin
            state <= WIT_ISSUE;
            bus.req <= 1'b1;
            bus.we <= 1'b1;
            bus.word <= 1'b1;
            bus.addr <= `WIT_WR_ADDR;
            bus.wdata <= {`WIT_PASS_CNT, `WIT_CNT_RESET};
          end
        end
        WIT_ISSUE: begin
          bus.req <= 1'b0;
          state <= WIT_WAIT;
        end
        WIT_WAIT: begin
          if (bus.ack) begin
            state <= WIT_IDLE;
            if (!bus.we) begin
              last_rdata <= bus.rdata;
            end
          end
        end
        default: state <= WIT_IDLE;
      endcase
    end
  end

endmodule : wit_host
`default_nettype wire

// *** test/wit_sva.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "wit_defs.svh"
module wit_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic req,
  input wire logic we,
  input wire logic word,
  input wire logic [15:0] addr,
  input wire logic [15:0] wdata,
  input wire logic ack,
  input wire logic [7:0] rdata,
  input wire logic chip_reset_n,
  input wire logic nmi_req,
  input wire logic overflow_irq,
  input wire logic overflow_flag,
  input wire logic [7:0] watchdog_count
);
  // cycles spent in chip reset, cleared while released
  logic [9:0] low_cnt;
  always_ff @(posedge aclk) begin
    if (!aresetn || chip_reset_n) begin
      low_cnt <= 10'h000;
    end else begin
      low_cnt <= low_cnt + 10'h001;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wrap;
    $past(watchdog_count) == 8'hff && watchdog_count == 8'h00;
  endsequence
  a_ack_follows: assert property (req |=> ack)
    else $error("ack missing after request");
  a_ack_cause: assert property (ack |-> $past(req))
    else $error("ack without request");
  a_irq_wraps: assert property ((nmi_req || overflow_irq) |-> s_wrap ##0 overflow_flag)
    else $error("request without counter wrap and flag");
  a_reset_cause: assert property ($fell(chip_reset_n) |-> s_wrap ##0
    (overflow_flag && !nmi_req && !overflow_irq))
    else $error("chip reset without wrap or with interrupt");
  a_mode_excl: assert property (nmi_req |-> !overflow_irq)
    else $error("nmi and interval request together");
  a_reset_hold: assert property ($rose(chip_reset_n) |-> low_cnt == 10'd518)
    else $error("chip reset length wrong");
  a_count_steps: assert property ((watchdog_count != $past(watchdog_count) && !$past(req))
    |-> (watchdog_count == $past(watchdog_count) + 8'h01 || watchdog_count == 8'h00))
    else $error("counter jumped");
  a_rsvd_one: assert property ((ack && $past(req && !we && addr == `WIT_CSR_RD_ADDR))
    |-> rdata[4] == `WIT_RSVD_VALUE)
    else $error("reserved bit reads zero");
  a_cnt_write_wins: assert property ((ack && $past(req && we && word && addr == `WIT_WR_ADDR
    && wdata[15:8] == `WIT_PASS_CNT)) |-> (watchdog_count == $past(wdata[7:0])
    || watchdog_count == 8'h00))
    else $error("count write lost");
endmodule : wit_sva
`default_nettype wire

// *** test/watchdog_interval_timer_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "wit_defs.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fails++; $display("BAD %0t got %h want %h", $time, (a), (b)); end end
module watchdog_interval_timer_tb
  import wit_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, overflow_flag;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] watchdog_count;
  logic [15:0] seed = 16'd6503;
  int fails = 0;
  int checks = 0;
  int div_tab [8] = '{2, 32, 64, 128, 256, 512, 2048, 4096};
  always #4 aclk = ~aclk;
  wit_bus_if bus_if ();
  // short kick period refreshes the count before it can wrap in the auto kick scenario
  wit_host #(.KICK_CYCLES(20)) wit_host_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdat), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .bus(bus_if));
  wit_device wit_device_inst (.aclk(aclk), .aresetn(aresetn), .bus(bus_if),
    .overflow_flag(overflow_flag), .watchdog_count(watchdog_count));
  wit_sva wit_sva_inst (.aclk(aclk), .aresetn(aresetn), .req(bus_if.req), .we(bus_if.we),
    .word(bus_if.word), .addr(bus_if.addr), .wdata(bus_if.wdata), .ack(bus_if.ack),
    .rdata(bus_if.rdata), .chip_reset_n(bus_if.chip_reset_n), .nmi_req(bus_if.nmi_req),
    .overflow_irq(bus_if.overflow_irq), .overflow_flag(overflow_flag),
    .watchdog_count(watchdog_count));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic logic [7:0] csr_val(input logic m, input logic r, input logic a,
                                         input logic [2:0] d);
    return {1'b0, m, r, `WIT_RSVD_VALUE, a, d};
  endfunction : csr_val
  task automatic finish_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test
  task automatic guard(input int n, input int lim);
    if (n >= lim) begin
      fails++;
      $display("BAD %0t wait timed out", $time);
      finish_test();
    end
  endtask : guard
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdat <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 100);
    guard(n, 100);
    bready <= 1'b0;
    `CHK(bresp, `WIT_AXI_OKAY)
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 100);
    guard(n, 100);
    d = rdata;
    rready <= 1'b0;
    `CHK(rresp, `WIT_AXI_OKAY)
  endtask : axi_rd
  task automatic dev(input logic [2:0] t, input logic [7:0] p, input logic [7:0] d,
                     output logic [7:0] q);
    logic [31:0] s;
    int n;
    axi_wr(8'h00, {13'h0, t, p, d});
    n = 0;
    do begin
      axi_rd(8'h04, s);
      n++;
    end while (s[0] !== 1'b0 && n < 50);
    guard(n, 50);
    q = s[15:8];
  endtask : dev
  task automatic cfg(input logic [7:0] v);
    logic [7:0] q;
    dev(WIT_T_WR_CSR, `WIT_PASS_CSR, (v & 8'hdf) ^ 8'h10, q);
    dev(WIT_T_WR_CSR, `WIT_PASS_CSR, v ^ 8'h10, q);
  endtask : cfg
  task automatic wait_ev(input int k, input int lim, output int n);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (!(k == 0 ? bus_if.overflow_irq : k == 1 ? bus_if.nmi_req : !bus_if.chip_reset_n)
               && n < lim);
    guard(n, lim);
  endtask : wait_ev
  task automatic measure(output int per);
    logic [7:0] v;
    int n;
    n = 0;
    v = watchdog_count;
    do begin @(posedge aclk); n++; end while (watchdog_count === v && n < 9000);
    guard(n, 9000);
    v = watchdog_count;
    per = 0;
    do begin @(posedge aclk); per++; end while (watchdog_count === v && per < 9000);
  endtask : measure
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] q, r8, p;
    logic [31:0] s;
    int n, c, per;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    dev(WIT_T_RD_CSR, 8'h00, 8'h00, q);
    `CHK(q, 8'h10)
    // target 7 issues nothing, so the last read data must survive
    dev(WIT_T_NONE, `WIT_PASS_CNT, 8'h55, q);
    `CHK(q, 8'h10)
    dev(WIT_T_WR_CNT, `WIT_PASS_CNT, 8'h77, q);
    dev(WIT_T_RD_CNT, 8'h00, 8'h00, q);
    `CHK(q, `WIT_CNT_RESET)
    for (c = 0; c < 8; c++) begin
      cfg(csr_val(1'b0, 1'b1, 1'b0, c[2:0]));
      measure(per);
      `CHK(per, div_tab[c])
    end
    dev(WIT_T_RD_CSR, 8'h00, 8'h00, q);
    `CHK(q & 8'h7f, csr_val(1'b0, 1'b1, 1'b0, 3'h7))
    cfg(csr_val(1'b0, 1'b1, 1'b0, 3'h0));
    wait_ev(0, 600, n);
    wait_ev(0, 600, n);
    `CHK(n, 256 * div_tab[0])
    `CHK(overflow_flag, 1'b1)
    axi_rd(8'h0c, s);
    `CHK(s[1], 1'b1)
    dev(WIT_T_RD_CSR, 8'h00, 8'h00, q);
    `CHK(q[`WIT_FLAG_BIT], 1'b1)
    dev(WIT_T_WR_CSR, `WIT_PASS_CSR, 8'h00, q);
    `CHK(overflow_flag, 1'b0)
    dev(WIT_T_WR_CSR, `WIT_PASS_CSR, 8'h80, q);
    `CHK(overflow_flag, 1'b0)
    cfg(csr_val(1'b1, 1'b1, 1'b0, 3'h1));
    dev(WIT_T_WR_CNT, `WIT_PASS_CNT, 8'hfe, q);
    wait_ev(1, 300, n);
    axi_rd(8'h0c, s);
    `CHK(s[0], 1'b1)
    cfg(csr_val(1'b1, 1'b1, 1'b1, 3'h1));
    dev(WIT_T_WR_CNT, `WIT_PASS_CNT, 8'hfe, q);
    wait_ev(2, 300, n);
    n = 0;
    while (bus_if.chip_reset_n !== 1'b1 && n < 600) begin @(posedge aclk); n++; end
    `CHK(n, 518)
    dev(WIT_T_RD_SYS, 8'h00, 8'h00, q);
    `CHK(q[`WIT_PIN_RST_BIT], 1'b0)
    dev(WIT_T_WR_CSR, `WIT_PASS_CSR, 8'h00, q);
    axi_wr(8'h0c, 32'h7);
    axi_rd(8'h0c, s);
    `CHK(s[2:0], 3'h0)
    cfg(csr_val(1'b1, 1'b1, 1'b1, 3'h0));
    axi_wr(8'h08, 32'h4);
    repeat (1500) @(posedge aclk);
    `CHK(bus_if.chip_reset_n, 1'b1)
    axi_wr(8'h08, 32'h0);
    repeat (10) @(posedge aclk);
    cfg(csr_val(1'b1, 1'b1, 1'b1, 3'h3));
    axi_wr(8'h08, 32'h2);
    dev(WIT_T_RD_CSR, 8'h00, 8'h00, q);
    `CHK(q, csr_val(1'b0, 1'b0, 1'b0, 3'h3))
    dev(WIT_T_RD_CNT, 8'h00, 8'h00, q);
    `CHK(q, 8'h00)
    cfg(csr_val(1'b0, 1'b1, 1'b0, 3'h0));
    // the extra edge shifts the phase so one write meets a tick
    dev(WIT_T_WR_CNT, `WIT_PASS_CNT, 8'h40, q);
    dev(WIT_T_WR_CNT, `WIT_PASS_CNT, 8'h40, q);
    @(posedge aclk);
    dev(WIT_T_WR_CNT, `WIT_PASS_CNT, 8'h40, q);
    cfg(csr_val(1'b0, 1'b1, 1'b0, 3'h7));
    repeat (6) begin
      seed = lfsr(seed);
      r8 = seed[7:0];
      p = (seed[15:8] == `WIT_PASS_CNT || seed[15:8] == `WIT_PASS_CSR) ? 8'h00 : seed[15:8];
      dev(WIT_T_WR_CNT, `WIT_PASS_CNT, r8, q);
      dev(WIT_T_RAW_WORD, p, ~r8, q);
      dev(WIT_T_RAW_BYTE, `WIT_PASS_CNT, ~r8, q);
      dev(WIT_T_RD_CNT, 8'h00, 8'h00, q);
      `CHK(q === r8 || q === r8 + 8'h01, 1'b1)
    end
    axi_rd(8'h1c, s);
    `CHK(s, 32'h0)
    axi_wr(8'h08, 32'h1);
    repeat (6) @(posedge aclk);
    axi_wr(8'h08, 32'h0);
    repeat (6) @(posedge aclk);
    dev(WIT_T_RD_SYS, 8'h00, 8'h00, q);
    `CHK(q[`WIT_PIN_RST_BIT], 1'b1)
    cfg(csr_val(1'b0, 1'b1, 1'b0, 3'h2));
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    dev(WIT_T_RD_CSR, 8'h00, 8'h00, q);
    `CHK(q, 8'h10)
    finish_test();
  end
endmodule : watchdog_interval_timer_tb
`default_nettype wire
